/* rtl/npc_pkg.sv */
// Operation
// - boot ROM of 512 bytes answers only in special modes with boot enable set.
// - utility sends an all-ones byte when ready; host then sends data from first location.
// - after the last byte and its echo, programming ends with a reset request.
// - with the OTP latch set, writes are captured and array reads are blocked.
// - OTP latch always readable; changes ignored while OTP voltage bit is set.
// - OTP voltage bit writable only while latch is 1; it connects array voltage.
// - multi-byte option, test mode only, ignores address bit five.
// - extra-column option, test mode only, disables user array, uses bits 11:5 and bit 0.
// - extra-row option, test mode only, disables user array, uses bits 5:0.
// - 640-byte EEPROM appears only when enabled, at the mapped 4-Kbyte boundary.
// - EEPROM program and erase act only on unprotected areas; control register always accessible.
// - with EEPROM latch clear, EEPROM reads like ROM.
// - charge pump uses system clock when select is 0, RC oscillator when 1.
// - EEPROM voltage only after latch write, valid array write, then latch plus voltage write.
// - one write setting both EEPROM latch and voltage while the latch is clear leaves both cleared.
// - low-voltage inhibit status bit is read-only and reads 0.
// - erase scope: both clear bulk, row set alone one 16-byte row, byte set one byte whatever the row bit.
// - erase-mode bit selects read or program when 0, erase when 1.
// - EEPROM voltage bit switches program or erase voltage onto the array.
// - odd-row and even-row half programming bits work only in test mode.
package npc_pkg;
    localparam logic [7:0] IDX_OTP_CTRL = 8'h2B;
    localparam logic [7:0] IDX_EE_CTRL = 8'h3B;
    localparam logic [7:0] IDX_MODE_CTRL = 8'h3C;
    localparam logic [7:0] IDX_DL_CTRL = 8'h3D;
    localparam logic [7:0] IDX_STATUS = 8'h3E;
    // otp control fields
    localparam int OTP_MBE = 7;
    localparam int OTP_LATCH = 5;
    localparam int OTP_EXTRA_COLUMN_SELECT = 4;
    localparam int OTP_EXTRA_ROW_SELECT = 3;
    localparam int OTP_VOLT = 0;
    // eeprom control fields
    localparam int EE_ODD = 7;
    localparam int EE_EVEN = 6;
    localparam int EE_LOW_VOLTAGE_INHIBIT = 5;
    localparam int EE_BYTE = 4;
    localparam int EE_ROW = 3;
    localparam int EE_ERASE = 2;
    localparam int EE_LATCH = 1;
    localparam int EE_VOLT = 0;
    // mode control fields
    localparam int MD_MAP_LO = 0;
    localparam int MD_MAP_HI = 3;
    localparam int MD_BOOT_EN = 4;
    localparam int MD_EE_EN = 5;
    localparam int MD_PUMP_SEL = 6;
    localparam int MD_WP_LO = 8;
    localparam int MD_WP_HI = 13;
    localparam int WP_CONFIG = 5;
    localparam logic [5:0] WP_RESET = 6'h3F;
    // download control fields
    localparam int DL_START = 0;
    localparam int DL_CNT_LO = 16;
    localparam int DL_CNT_HI = 31;
    // status fields
    localparam int ST_DL_BUSY = 0;
    localparam int ST_EE_VOLT = 1;
    localparam int ST_OTP_VOLT = 2;
    localparam int ST_LOADED = 3;
    localparam int ST_SPECIAL = 4;
    localparam int ST_TEST = 5;
    // memory map
    localparam logic [15:0] BOOT_ROM_BASE = 16'hBE00;
    localparam int BOOT_ROM_BITS = 9;
    localparam logic [15:0] OTP_BASE_DEF = 16'hA000;
    localparam logic [15:0] CONFIG_ADDR = 16'h003F;
    localparam logic [11:0] EE_LO = 12'hD80;
    localparam logic [11:0] EE_B1 = 12'hDA0;
    localparam logic [11:0] EE_B2 = 12'hDE0;
    localparam logic [11:0] EE_B3 = 12'hE60;
    localparam logic [11:0] EE_B4 = 12'hF80;
    localparam logic [11:0] OTP_MASK_MBE = 12'hFDF;
    localparam logic [11:0] OTP_MASK_EXTRA_COLUMN_SELECT = 12'hFE1;
    localparam logic [11:0] OTP_MASK_EXTRA_ROW_SELECT = 12'h03F;
    localparam logic [7:0] DL_READY_BYTE = 8'hFF;
    localparam int PUMP_DIV_DEF = 4;

    typedef enum logic [1:0] {SCOPE_BULK, SCOPE_ROW, SCOPE_BYTE} npc_scope_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_LOADED} npc_seq_t;
    typedef enum logic [1:0] {DL_IDLE, DL_READY, DL_WAIT, DL_RESET} npc_dl_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } npc_mem_req_t;
endpackage

/* rtl/npc_sync.sv */
`timescale 1ns/100ps
module npc_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            stage <= '0;
            sync_out <= '0;
        end else begin
            stage <= async_in;
            sync_out <= stage;
        end
    end
endmodule

/* rtl/npc_pump_tick.sv */
`timescale 1ns/100ps
module npc_pump_tick #(
    parameter int DIV = 4
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sel_rc,
    input wire logic rc_sync,
    output logic pump_tick
);
    logic [15:0] count;
    logic rc_last;

    // system-clock tick from a divider, rc tick from rising edges of the oscillator
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            count <= '0;
            rc_last <= 1'b0;
            pump_tick <= 1'b0;
        end else begin
            rc_last <= rc_sync;
            if (sel_rc) begin
                count <= '0;
                pump_tick <= rc_sync & ~rc_last;
            end else if (count == 16'(DIV - 1)) begin
                count <= '0;
                pump_tick <= 1'b1;
            end else begin
                count <= count + 16'h0001;
                pump_tick <= 1'b0;
            end
        end
    end
endmodule

/* rtl/npc_top.sv */
`timescale 1ns/100ps
module npc_top
    import npc_pkg::*;
#(
    parameter logic [15:0] OTP_BASE = OTP_BASE_DEF,
    parameter int PUMP_DIV = PUMP_DIV_DEF
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic special_mode_pin,
    input wire logic test_mode_pin,
    input wire logic rc_osc_pin,
    input wire npc_mem_req_t mem_req,
    input wire logic host_rx_valid,
    input wire logic [7:0] host_rx_data,
    output logic host_tx_valid,
    output logic [7:0] host_tx_data,
    output logic reset_request,
    output logic boot_rom_select,
    output logic otp_read_enable,
    output logic [11:0] otp_prog_addr,
    output logic [7:0] otp_prog_data,
    output logic otp_voltage_enable,
    output logic otp_user_array_disable,
    output logic eeprom_select,
    output logic eeprom_read_enable,
    output logic [15:0] ee_prog_addr,
    output logic [7:0] ee_prog_data,
    output logic ee_voltage_enable,
    output logic ee_erase_mode,
    output npc_scope_t ee_erase_scope,
    output logic ee_half_odd,
    output logic ee_half_even,
    output logic pump_clock_select,
    output logic pump_tick
);
    logic [2:0] sync_bus;
    logic special_mode;
    logic test_mode;
    logic rc_osc;
    logic otp_mbe, otp_latch, otp_extra_column_select, otp_extra_row_select, otp_volt;
    logic ee_odd, ee_even, ee_byte, ee_row, ee_erase, ee_latch, ee_volt;
    logic [3:0] ee_map;
    logic boot_rom_enable, eeprom_enable, pump_sel;
    logic [5:0] wprot;
    logic ee_to_config;
    npc_seq_t seq_state;
    npc_dl_t dl_state;
    logic [15:0] dl_count;
    logic [31:0] rd_val;
    logic apb_wr, wr_otp, wr_ee, wr_mode, wr_dl;
    logic mem_wr, ee_hit, cfg_hit, otp_hit, boot_hit, boot_active, ee_target_prot;
    npc_scope_t next_scope;

    function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
        return a == {2'b00, idx, 2'b00};
    endfunction

    function automatic logic [2:0] ee_block(input logic [11:0] a);
        if (a < EE_B1) return 3'h0;
        else if (a < EE_B2) return 3'h1;
        else if (a < EE_B3) return 3'h2;
        else if (a < EE_B4) return 3'h3;
        else return 3'h4;
    endfunction

    function automatic logic [11:0] otp_map(input logic [11:0] a, input logic multi_byte_program,
                                            input logic extra_column_select, input logic extra_row_select);
        logic [11:0] m;
        m = a;
        if (multi_byte_program) m = m & OTP_MASK_MBE;
        if (extra_column_select) m = m & OTP_MASK_EXTRA_COLUMN_SELECT;
        if (extra_row_select) m = m & OTP_MASK_EXTRA_ROW_SELECT;
        return m;
    endfunction

    npc_sync #(.W(3)) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in({special_mode_pin, test_mode_pin, rc_osc_pin}),
        .sync_out(sync_bus)
    );
    assign special_mode = sync_bus[2];
    assign test_mode = sync_bus[1];
    assign rc_osc = sync_bus[0];

    npc_pump_tick #(.DIV(PUMP_DIV)) u_pump (
        .mclk(mclk),
        .reset_n(reset_n),
        .sel_rc(pump_sel),
        .rc_sync(rc_osc),
        .pump_tick(pump_tick)
    );

    // apb: one wait state, write takes effect on the edge that samples pready
    assign apb_wr = psel & penable & pready & pwrite;
    assign wr_otp = apb_wr & reg_hit(paddr, IDX_OTP_CTRL);
    assign wr_ee = apb_wr & reg_hit(paddr, IDX_EE_CTRL);
    assign wr_mode = apb_wr & reg_hit(paddr, IDX_MODE_CTRL);
    assign wr_dl = apb_wr & reg_hit(paddr, IDX_DL_CTRL);

    assign mem_wr = mem_req.valid & mem_req.write;
    assign ee_hit = eeprom_enable && mem_req.addr[15:12] == ee_map && mem_req.addr[11:0] >= EE_LO;
    assign cfg_hit = mem_req.addr == CONFIG_ADDR;
    assign otp_hit = mem_req.addr >= OTP_BASE;
    assign boot_hit = mem_req.addr[15:BOOT_ROM_BITS] == BOOT_ROM_BASE[15:BOOT_ROM_BITS];
    assign boot_active = special_mode & boot_rom_enable;
    assign ee_target_prot = ee_to_config ? wprot[WP_CONFIG] : wprot[ee_block(ee_prog_addr[11:0])];

    always_comb begin
        rd_val = '0;
        case (paddr[9:2])
            IDX_OTP_CTRL: begin
                rd_val[OTP_MBE] = otp_mbe;
                rd_val[OTP_LATCH] = otp_latch;
                rd_val[OTP_EXTRA_COLUMN_SELECT] = otp_extra_column_select;
                rd_val[OTP_EXTRA_ROW_SELECT] = otp_extra_row_select;
                rd_val[OTP_VOLT] = otp_volt;
            end
            IDX_EE_CTRL: begin
                rd_val[EE_ODD] = ee_odd;
                rd_val[EE_EVEN] = ee_even;
                rd_val[EE_LOW_VOLTAGE_INHIBIT] = 1'b0;
                rd_val[EE_BYTE] = ee_byte;
                rd_val[EE_ROW] = ee_row;
                rd_val[EE_ERASE] = ee_erase;
                rd_val[EE_LATCH] = ee_latch;
                rd_val[EE_VOLT] = ee_volt;
            end
            IDX_MODE_CTRL: begin
                rd_val[MD_MAP_HI:MD_MAP_LO] = ee_map;
                rd_val[MD_BOOT_EN] = boot_rom_enable;
                rd_val[MD_EE_EN] = eeprom_enable;
                rd_val[MD_PUMP_SEL] = pump_sel;
                rd_val[MD_WP_HI:MD_WP_LO] = wprot;
            end
            IDX_DL_CTRL: rd_val[DL_CNT_HI:DL_CNT_LO] = dl_count;
            IDX_STATUS: begin
                rd_val[ST_DL_BUSY] = dl_state != DL_IDLE;
                rd_val[ST_EE_VOLT] = ee_voltage_enable;
                rd_val[ST_OTP_VOLT] = otp_voltage_enable;
                rd_val[ST_LOADED] = seq_state == SEQ_LOADED;
                rd_val[ST_SPECIAL] = special_mode;
                rd_val[ST_TEST] = test_mode;
            end
            default: rd_val = '0;
        endcase
        if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) rd_val = '0;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel & penable & ~pready) begin
                prdata <= rd_val;
                pslverr <= ~(reg_hit(paddr, IDX_OTP_CTRL) | reg_hit(paddr, IDX_EE_CTRL) |
                             reg_hit(paddr, IDX_MODE_CTRL) | reg_hit(paddr, IDX_DL_CTRL) |
                             reg_hit(paddr, IDX_STATUS));
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ee_map <= '0;
            boot_rom_enable <= 1'b0;
            eeprom_enable <= 1'b0;
            pump_sel <= 1'b0;
            wprot <= WP_RESET;
        end else if (wr_mode) begin
            ee_map <= pwdata[MD_MAP_HI:MD_MAP_LO];
            boot_rom_enable <= pwdata[MD_BOOT_EN];
            eeprom_enable <= pwdata[MD_EE_EN];
            pump_sel <= pwdata[MD_PUMP_SEL];
            wprot <= pwdata[MD_WP_HI:MD_WP_LO];
        end
    end

    // otp latch and voltage interlock
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            otp_latch <= 1'b0;
            otp_volt <= 1'b0;
        end else if (wr_otp) begin
            if (!otp_volt) otp_latch <= pwdata[OTP_LATCH];
            if (otp_latch) otp_volt <= pwdata[OTP_VOLT];
        end
    end

    // factory bits drop back to reset value outside test mode
    always_ff @(posedge mclk) begin
        if (!reset_n || !test_mode) begin
            otp_mbe <= 1'b0;
            otp_extra_column_select <= 1'b0;
            otp_extra_row_select <= 1'b0;
        end else if (wr_otp) begin
            otp_mbe <= pwdata[OTP_MBE];
            otp_extra_column_select <= pwdata[OTP_EXTRA_COLUMN_SELECT];
            otp_extra_row_select <= pwdata[OTP_EXTRA_ROW_SELECT];
        end
    end

    // capture array writes while latched; voltage on freezes the captured word
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            otp_prog_addr <= '0;
            otp_prog_data <= '0;
        end else if (mem_wr && otp_hit && otp_latch && !otp_volt) begin
            otp_prog_addr <= otp_map(mem_req.addr[11:0], otp_mbe, otp_extra_column_select, otp_extra_row_select);
            otp_prog_data <= mem_req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n || !test_mode) begin
            ee_odd <= 1'b0;
            ee_even <= 1'b0;
        end else if (wr_ee) begin
            ee_odd <= pwdata[EE_ODD];
            ee_even <= pwdata[EE_EVEN];
        end
    end

    // control register stays writable; the voltage bit only follows the sequence
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ee_byte <= 1'b0;
            ee_row <= 1'b0;
            ee_erase <= 1'b0;
            ee_latch <= 1'b0;
            ee_volt <= 1'b0;
        end else if (wr_ee) begin
            ee_byte <= pwdata[EE_BYTE];
            ee_row <= pwdata[EE_ROW];
            ee_erase <= pwdata[EE_ERASE];
            if (pwdata[EE_LATCH] && pwdata[EE_VOLT]) begin
                if (!ee_latch) begin
                    ee_latch <= 1'b0;
                    ee_volt <= 1'b0;
                end else begin
                    ee_volt <= seq_state == SEQ_LOADED && !ee_target_prot;
                end
            end else begin
                ee_latch <= pwdata[EE_LATCH];
                ee_volt <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            seq_state <= SEQ_IDLE;
        end else if (wr_ee) begin
            if (!pwdata[EE_LATCH]) seq_state <= SEQ_IDLE;
            else if (!pwdata[EE_VOLT]) seq_state <= SEQ_ARMED;
            else if (!ee_latch) seq_state <= SEQ_IDLE;
        end else begin
            unique case (seq_state)
                SEQ_IDLE: seq_state <= SEQ_IDLE;
                SEQ_ARMED: if (mem_wr && (ee_hit || cfg_hit)) seq_state <= SEQ_LOADED;
                SEQ_LOADED: seq_state <= SEQ_LOADED;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ee_prog_addr <= '0;
            ee_prog_data <= '0;
            ee_to_config <= 1'b0;
        end else if (mem_wr && (ee_hit || cfg_hit) && ee_latch && !ee_volt) begin
            ee_prog_addr <= mem_req.addr;
            ee_prog_data <= mem_req.wdata;
            ee_to_config <= cfg_hit;
        end
    end

    always_comb begin
        if (ee_byte) next_scope = SCOPE_BYTE;
        else if (ee_row) next_scope = SCOPE_ROW;
        else next_scope = SCOPE_BULK;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            boot_rom_select <= 1'b0;
            otp_read_enable <= 1'b1;
            otp_voltage_enable <= 1'b0;
            otp_user_array_disable <= 1'b0;
            eeprom_select <= 1'b0;
            eeprom_read_enable <= 1'b1;
            ee_voltage_enable <= 1'b0;
            ee_erase_mode <= 1'b0;
            ee_erase_scope <= SCOPE_BULK;
            ee_half_odd <= 1'b0;
            ee_half_even <= 1'b0;
            pump_clock_select <= 1'b0;
        end else begin
            boot_rom_select <= mem_req.valid & ~mem_req.write & boot_hit & boot_active;
            otp_read_enable <= ~otp_latch;
            otp_voltage_enable <= otp_volt;
            otp_user_array_disable <= otp_extra_column_select | otp_extra_row_select;
            eeprom_select <= mem_req.valid & ee_hit;
            eeprom_read_enable <= ~ee_latch;
            ee_voltage_enable <= ee_volt & ee_latch;
            ee_erase_mode <= ee_erase;
            ee_erase_scope <= next_scope;
            ee_half_odd <= ee_odd;
            ee_half_even <= ee_even;
            pump_clock_select <= pump_sel;
        end
    end

    // download responder for the resident programming utility
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dl_state <= DL_IDLE;
            dl_count <= '0;
            host_tx_valid <= 1'b0;
            host_tx_data <= '0;
            reset_request <= 1'b0;
        end else begin
            host_tx_valid <= 1'b0;
            reset_request <= 1'b0;
            unique case (dl_state)
                DL_IDLE: if (wr_dl && pwdata[DL_START] && boot_active) begin
                    dl_count <= pwdata[DL_CNT_HI:DL_CNT_LO];
                    dl_state <= DL_READY;
                end
                DL_READY: begin
                    host_tx_valid <= 1'b1;
                    host_tx_data <= DL_READY_BYTE;
                    dl_state <= DL_WAIT;
                end
                DL_WAIT: if (host_rx_valid) begin
                    host_tx_valid <= 1'b1;
                    host_tx_data <= host_rx_data;
                    dl_count <= dl_count - 16'h0001;
                    if (dl_count <= 16'h0001) dl_state <= DL_RESET;
                end
                DL_RESET: begin
                    reset_request <= 1'b1;
                    dl_count <= '0;
                    dl_state <= DL_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_ee_arm;
        wr_ee && pwdata[EE_LATCH] && !pwdata[EE_VOLT];
    endsequence
    sequence s_ee_load;
        mem_wr && (ee_hit || cfg_hit);
    endsequence
    sequence s_dl_start;
        dl_state == DL_IDLE && wr_dl && pwdata[DL_START] && boot_active;
    endsequence

    a_otp_latch_hold: assert property (wr_otp && otp_volt |=> $stable(otp_latch))
        else $error("otp latch changed while voltage set");
    a_otp_volt_gate: assert property (wr_otp && !otp_latch |=> $stable(otp_volt))
        else $error("otp voltage changed without latch");
    a_otp_read_block: assert property (wr_otp && !otp_volt && pwdata[OTP_LATCH] |=> ##1 !otp_read_enable)
        else $error("otp read not blocked after latch");
    a_ee_both_clear: assert property (wr_ee && !ee_latch && pwdata[EE_LATCH] && pwdata[EE_VOLT]
        |=> !ee_latch && !ee_volt ##1 !ee_voltage_enable)
        else $error("ee latch and voltage set together");
    a_ee_volt_seq: assert property ($rose(ee_volt) |-> $past(seq_state) == SEQ_LOADED)
        else $error("ee voltage without full sequence");
    a_ee_seq_load: assert property (s_ee_arm ##1 (s_ee_load and !wr_ee) |=> seq_state == SEQ_LOADED)
        else $error("ee sequence did not load");
    a_low_voltage_inhibit_reads_zero: assert property (pready && reg_hit(paddr, IDX_EE_CTRL) |-> !prdata[EE_LOW_VOLTAGE_INHIBIT])
        else $error("inhibit bit read as one");
    a_boot_rom_gate: assert property (boot_rom_select |-> $past(special_mode && boot_rom_enable))
        else $error("boot rom selected outside special mode");
    a_test_bits_lock: assert property (!test_mode |=> !otp_mbe && !otp_extra_column_select && !otp_extra_row_select && !ee_odd)
        else $error("factory bit set outside test mode");
    a_dl_ready_byte: assert property (s_dl_start |=> ##1 host_tx_valid && host_tx_data == DL_READY_BYTE)
        else $error("ready byte not sent");
    a_erase_scope: assert property (ee_byte |=> ee_erase_scope == SCOPE_BYTE)
        else $error("byte erase scope wrong");
endmodule

/* bench/tb_nvm_program_control.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_nvm_program_control;
    import npc_pkg::*;
    logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, perr;
    logic [11:0] paddr = '0, otp_prog_addr;
    logic [31:0] pwdata = '0, prdata, rd;
    logic special_mode_pin = 0, test_mode_pin = 0, rc_osc_pin = 0, host_rx_valid = 0;
    logic [7:0] host_rx_data = '0, host_tx_data, otp_prog_data, ee_prog_data;
    npc_mem_req_t mem_req = '0;
    logic host_tx_valid, reset_request, boot_rom_select, otp_read_enable, otp_voltage_enable;
    logic otp_user_array_disable, eeprom_select, eeprom_read_enable, ee_voltage_enable, ee_erase_mode;
    logic ee_half_odd, ee_half_even, pump_clock_select, pump_tick;
    logic [15:0] ee_prog_addr;
    npc_scope_t ee_erase_scope;
    int errors = 0, total_checks = 0;
    npc_top uut (.*);
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge mclk);
        psel <= 1; pwrite <= w; paddr <= {2'b00, idx, 2'b00}; pwdata <= wd; penable <= 0;
        @(posedge mclk);
        penable <= 1;
        n = 0;
        do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin errors++; summarize(); end
        rd = prdata; perr = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic mem(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        mem_req <= '{1'b1, 1'b1, a, d};
        @(posedge mclk);
        mem_req <= '0;
        #1;
    endtask
    task automatic t_reset;
        int ticks;
        apb(0, IDX_OTP_CTRL, 0); `CHK("otp ctrl reset", 32'h0, rd)
        `CHK("otp rd en", 1'b1, otp_read_enable)
        `CHK("ee rd en", 1'b1, eeprom_read_enable)
        ticks = 0;
        repeat (16) begin
            @(posedge mclk);
            #1;
            ticks += pump_tick;
        end
        `CHK("pump ticks", 16 / PUMP_DIV_DEF, ticks)
    endtask
    task automatic t_otp;
        apb(1, IDX_OTP_CTRL, 32'h01); apb(0, IDX_OTP_CTRL, 0); `CHK("volt w/o latch", 32'h0, rd)
        apb(1, IDX_OTP_CTRL, 32'h20); mem(16'hA123, 8'h5A);
        `CHK("otp addr", 12'h123, otp_prog_addr)
        `CHK("otp data", 8'h5A, otp_prog_data)
        `CHK("otp rd blocked", 1'b0, otp_read_enable)
        apb(1, IDX_OTP_CTRL, 32'h21); settle; `CHK("otp volt", 1'b1, otp_voltage_enable)
        apb(1, IDX_OTP_CTRL, 32'h01); apb(0, IDX_OTP_CTRL, 0); `CHK("latch held", 32'h21, rd)
        apb(1, IDX_OTP_CTRL, 32'h20); settle; `CHK("otp volt off", 1'b0, otp_voltage_enable)
        apb(1, IDX_OTP_CTRL, 32'h00); settle; `CHK("otp rd back", 1'b1, otp_read_enable)
        mem(16'hA456, 8'h11); `CHK("no capture", 12'h123, otp_prog_addr)
    endtask
    task automatic t_test;
        apb(1, IDX_OTP_CTRL, 32'h98); apb(0, IDX_OTP_CTRL, 0); `CHK("test bits", 32'h0, rd)
        apb(1, IDX_EE_CTRL, 32'hC0); apb(0, IDX_EE_CTRL, 0); `CHK("half bits", 32'h0, rd)
        test_mode_pin <= 1;
        apb(1, IDX_OTP_CTRL, 32'h30); settle; `CHK("user off", 1'b1, otp_user_array_disable)
        mem(16'hA123, 8'h11); `CHK("col mask", 12'h121, otp_prog_addr)
        apb(1, IDX_OTP_CTRL, 32'h28); mem(16'hA3E7, 8'h22); `CHK("row mask", 12'h027, otp_prog_addr)
        apb(1, IDX_OTP_CTRL, 32'hA0); mem(16'hA123, 8'h33); `CHK("mbe mask", 12'h103, otp_prog_addr)
        apb(1, IDX_EE_CTRL, 32'hC0); settle; `CHK("odd half", 1'b1, ee_half_odd)
        `CHK("even half", 1'b1, ee_half_even)
        apb(1, IDX_EE_CTRL, 32'h00); apb(1, IDX_OTP_CTRL, 32'h00);
        test_mode_pin <= 0;
    endtask
    task automatic t_ee;
        logic [7:0] ctl [4] = '{8'h06, 8'h0E, 8'h16, 8'h1E};
        npc_scope_t sc [4] = '{SCOPE_BULK, SCOPE_ROW, SCOPE_BYTE, SCOPE_BYTE};
        apb(1, IDX_MODE_CTRL, 32'h60); settle; `CHK("pump rc", 1'b1, pump_clock_select)
        apb(1, IDX_EE_CTRL, 32'h23); apb(0, IDX_EE_CTRL, 0); `CHK("both set", 32'h0, rd)
        apb(1, IDX_EE_CTRL, 32'h02); apb(1, IDX_EE_CTRL, 32'h03); settle;
        `CHK("no load", 1'b0, ee_voltage_enable)
        apb(1, IDX_EE_CTRL, 32'h02); mem(16'h0D85, 8'hA5);
        `CHK("ee addr", 16'h0D85, ee_prog_addr)
        `CHK("ee data", 8'hA5, ee_prog_data)
        `CHK("ee sel", 1'b1, eeprom_select)
        apb(1, IDX_EE_CTRL, 32'h03); settle; `CHK("ee volt", 1'b1, ee_voltage_enable)
        apb(1, IDX_EE_CTRL, 32'h00); settle; `CHK("ee volt off", 1'b0, ee_voltage_enable)
        `CHK("ee rom read", 1'b1, eeprom_read_enable)
        for (int i = 0; i < 4; i++) begin
            apb(1, IDX_EE_CTRL, {24'h0, ctl[i]}); settle;
            `CHK("scope", sc[i], ee_erase_scope)
            `CHK("erase", 1'b1, ee_erase_mode)
        end
        apb(1, IDX_EE_CTRL, 32'h00); apb(1, IDX_MODE_CTRL, 32'h3F20);
        apb(1, IDX_EE_CTRL, 32'h02); mem(16'h0D85, 8'hA5); apb(1, IDX_EE_CTRL, 32'h03); settle;
        `CHK("protected", 1'b0, ee_voltage_enable)
        apb(1, IDX_EE_CTRL, 32'h00);
    endtask
    task automatic t_dl;
        int n;
        logic [7:0] dl [3] = '{8'h7E, 8'h5A, 8'hC3};
        special_mode_pin <= 1;
        apb(1, IDX_MODE_CTRL, 32'h10);
        @(posedge mclk);
        mem_req <= '{1'b1, 1'b0, 16'hBE10, 8'h00};
        @(posedge mclk);
        mem_req <= '0;
        #1;
        `CHK("boot sel", 1'b1, boot_rom_select)
        apb(1, IDX_DL_CTRL, 32'h0003_0001);
        n = 0;
        do begin @(posedge mclk); #1; n++; end while (host_tx_valid !== 1'b1 && n < 20);
        if (n >= 20) begin errors++; summarize(); end
        `CHK("ready byte", 8'hFF, host_tx_data)
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            host_rx_valid <= 1;
            host_rx_data <= dl[i];
            @(posedge mclk);
            host_rx_valid <= 0;
            #1;
            `CHK("echo", dl[i], host_tx_data)
        end
        @(posedge mclk); #1; `CHK("reset req", 1'b1, reset_request)
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        reset_n <= 1;
        t_reset(); t_otp(); t_test(); t_ee(); t_dl();
        apb(0, 8'h01, 0); `CHK("unmapped err", 1'b1, perr) `CHK("unmapped rd", 32'h0, rd)
        summarize();
    end
endmodule
